/* src/fs2_status_regs.sv */
// Second volatile status register with interrupt status and mask, AXI4-Lite slave.
// Assumes core events arrive on aclk as one-cycle pulses; one access of each kind at a time.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
module fs2_status_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Flash core events
  input fs2_pkg::fs2_core_evt_t core_evt,
  output fs2_pkg::fs2_crc_ans_t crc_ans,
  // AXI4-Lite write address
  input wire logic [fs2_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [fs2_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Declarations
  logic [fs2_pkg::FLAG_N-1:0] flags_q, flags_d;
  logic [fs2_pkg::FLAG_N-1:0] mask_q, mask_d;
  logic [fs2_pkg::FLAG_N-1:0] irq_stat;
  logic [fs2_pkg::FLAG_N-1:0] irq_evt;
  logic [fs2_pkg::STATUS_W-1:0] status_view;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [fs2_pkg::AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic rd_status_q, rd_status_d;
  logic aw_hs, w_hs, ar_hs, wr_fire, irq_rd_clr;

  // ==========================================================
  // Range check of CRC requests
  fs2_crc_check u_crc_check (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(core_evt.crc_req),
    .start_addr(core_evt.crc_start_address),
    .end_addr(core_evt.crc_end_address),
    .ans_q(crc_ans)
  );

  // ==========================================================
  // Status flags, driven only by the core
  always_comb begin
    flags_d = flags_q;
    if (crc_ans.abort) begin
      flags_d[fs2_pkg::CRC_ABORT_BIT] = 1'b1;
    end else if (crc_ans.go) begin
      flags_d[fs2_pkg::CRC_ABORT_BIT] = 1'b0;
    end
    if (core_evt.eval_cmd) begin
      flags_d[fs2_pkg::SECT_RES_BIT] = core_evt.eval_erased_ok;
    end
    // Entry wins over exit if the core reports both at once
    if (core_evt.erase_susp_set) begin
      flags_d[fs2_pkg::ERASE_SUSP_BIT] = 1'b1;
    end else if (core_evt.erase_susp_clr) begin
      flags_d[fs2_pkg::ERASE_SUSP_BIT] = 1'b0;
    end
    if (core_evt.prog_susp_set) begin
      flags_d[fs2_pkg::PROG_SUSP_BIT] = 1'b1;
    end else if (core_evt.prog_susp_clr) begin
      flags_d[fs2_pkg::PROG_SUSP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= fs2_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Reserved bits are tied low
  assign status_view = {3'h0, 1'b0, flags_q};

  // ==========================================================
  // Interrupt status, read to clear
  always_comb begin
    irq_evt = '0;
    irq_evt[fs2_pkg::CRC_ABORT_BIT] = crc_ans.abort;
    irq_evt[fs2_pkg::SECT_RES_BIT] = core_evt.eval_cmd;
    irq_evt[fs2_pkg::ERASE_SUSP_BIT] = core_evt.erase_susp_set;
    irq_evt[fs2_pkg::PROG_SUSP_BIT] = core_evt.prog_susp_set;
  end

  for (genvar i = 0; i < fs2_pkg::FLAG_N; i++) begin : g_irq
    fs2_sticky_bit u_bit (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(irq_evt[i]),
      .clr(irq_rd_clr),
      .q(irq_stat[i])
    );
  end

  assign irq = |(irq_stat & mask_q);

  // ==========================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_got_q || aw_hs) && (w_got_q || w_hs);

  always_comb begin
    logic [fs2_pkg::AXI_AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    wa = aw_hs ? s_axi_awaddr : awaddr_q;
    wd = w_hs ? s_axi_wdata : wdata_q;
    ws = w_hs ? s_axi_wstrb : wstrb_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = wa;
    wdata_d = wd;
    wstrb_d = ws;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    mask_d = mask_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_hs) begin
      aw_got_d = 1'b1;
    end
    if (w_hs) begin
      w_got_d = 1'b1;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = fs2_pkg::RESP_OKAY;
      case ({wa[fs2_pkg::AXI_AW-1:2], 2'h0})
        fs2_pkg::STATUS_OFS: begin
          // Status is core-owned: the write is answered and dropped
          bresp_d = fs2_pkg::RESP_OKAY;
        end
        fs2_pkg::IRQ_STAT_OFS: begin
          bresp_d = fs2_pkg::RESP_OKAY;
        end
        fs2_pkg::IRQ_MASK_OFS: begin
          if (ws[0]) begin
            mask_d = wd[fs2_pkg::FLAG_N-1:0];
          end
        end
        default: begin
          bresp_d = fs2_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= fs2_pkg::RESP_OKAY;
      mask_q <= fs2_pkg::MASK_RST;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      mask_q <= mask_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================
  // Read channel: data registered one cycle after the address
  assign s_axi_arready = !rvalid_q;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    rd_status_d = rd_status_q;
    irq_rd_clr = 1'b0;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d = fs2_pkg::RESP_OKAY;
      rdata_d = 32'h00000000;
      rd_status_d = 1'b0;
      case ({s_axi_araddr[fs2_pkg::AXI_AW-1:2], 2'h0})
        fs2_pkg::STATUS_OFS: begin
          rdata_d[fs2_pkg::STATUS_W-1:0] = status_view;
          rd_status_d = 1'b1;
        end
        fs2_pkg::IRQ_STAT_OFS: begin
          rdata_d[fs2_pkg::FLAG_N-1:0] = irq_stat;
          irq_rd_clr = 1'b1;
        end
        fs2_pkg::IRQ_MASK_OFS: begin
          rdata_d[fs2_pkg::FLAG_N-1:0] = mask_q;
        end
        default: begin
          rresp_d = fs2_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= fs2_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      rd_status_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      rd_status_q <= rd_status_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ==========================================================
  // Assertions
  logic req_short, req_long, no_evt;
  assign req_short = core_evt.crc_req && ({1'b0, core_evt.crc_end_address} <
    ({1'b0, core_evt.crc_start_address} + fs2_pkg::CRC_MIN_SPAN));
  assign req_long = core_evt.crc_req && !req_short;
  assign no_evt = !core_evt.crc_req && !crc_ans.go && !crc_ans.abort && !core_evt.eval_cmd
    && !core_evt.erase_susp_set && !core_evt.erase_susp_clr
    && !core_evt.prog_susp_set && !core_evt.prog_susp_clr;

  property p_crc_abort_sets;
    @(posedge aclk) disable iff (!aresetn)
    req_short |=> (crc_ans.abort && !crc_ans.go) ##1 flags_q[fs2_pkg::CRC_ABORT_BIT];
  endproperty
  a_crc_abort_sets: assert property (p_crc_abort_sets)
    else $error("short CRC range did not abort");

  property p_crc_clears;
    @(posedge aclk) disable iff (!aresetn)
    req_long |=> crc_ans.go ##1 !flags_q[fs2_pkg::CRC_ABORT_BIT];
  endproperty
  a_crc_clears: assert property (p_crc_clears)
    else $error("valid CRC range did not clear abort flag");

  property p_crc_read;
    @(posedge aclk) disable iff (!aresetn)
    ar_hs && rd_status_d |=> s_axi_rdata[3] == $past(flags_q[fs2_pkg::CRC_ABORT_BIT]);
  endproperty
  a_crc_read: assert property (p_crc_read)
    else $error("abort flag read value wrong");

  property p_eval_result;
    @(posedge aclk) disable iff (!aresetn)
    core_evt.eval_cmd |=> flags_q[fs2_pkg::SECT_RES_BIT] == $past(core_evt.eval_erased_ok);
  endproperty
  a_eval_result: assert property (p_eval_result)
    else $error("sector result not taken from evaluation");

  property p_erase_susp;
    @(posedge aclk) disable iff (!aresetn)
    core_evt.erase_susp_clr && !core_evt.erase_susp_set |=> !flags_q[fs2_pkg::ERASE_SUSP_BIT];
  endproperty
  a_erase_susp: assert property (p_erase_susp)
    else $error("erase suspend flag stuck after resume");

  property p_prog_susp;
    @(posedge aclk) disable iff (!aresetn)
    core_evt.prog_susp_set |=> flags_q[fs2_pkg::PROG_SUSP_BIT];
  endproperty
  a_prog_susp: assert property (p_prog_susp)
    else $error("program suspend flag not set");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    rvalid_q && rd_status_q |-> s_axi_rdata[31:4] == 28'h0000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits not zero");

  property p_ro_stable;
    @(posedge aclk) disable iff (!aresetn)
    no_evt |=> $stable(flags_q);
  endproperty
  a_ro_stable: assert property (p_ro_stable)
    else $error("status changed without a core event");

  property p_irq_follows;
    @(posedge aclk) disable iff (!aresetn)
    crc_ans.abort && mask_q[fs2_pkg::CRC_ABORT_BIT] && !(mask_d != mask_q) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("unmasked abort did not raise interrupt");

endmodule

/* src/fs2_pkg.sv */
// Constants, field layout and carrier types for the second volatile status register.
// Assumes one 25 MHz clock, synchronous active-low reset, AXI4-Lite register access.
//
// Notes on behaviour
// - CRC request with end below start plus 3 sets abort flag, skips calculation.
// - Next CRC request with end at least start plus 3 clears abort flag.
// - Abort flag reads 0 when not aborted, 1 when aborted.
// - Sector result flag reads 1 when last evaluated sector erased successfully.
// - Erase-suspended flag is 1 while an erase is suspended, else 0.
// - Program-suspended flag is 1 while a program is suspended, else 0.
// - Upper four register bits are reserved and read as zero.
package fs2_pkg;

  // ==========================================================
  // Register map
  localparam int AXI_AW = 8;
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;

  // ==========================================================
  // Field layout of the status register
  localparam int STATUS_W = 8;
  localparam int FLAG_N = 4;
  localparam int PROG_SUSP_BIT = 0;
  localparam int ERASE_SUSP_BIT = 1;
  localparam int SECT_RES_BIT = 2;
  localparam int CRC_ABORT_BIT = 3;

  // ==========================================================
  // Reset values and misc
  localparam logic [FLAG_N-1:0] FLAGS_RST = 4'h0;
  localparam logic [FLAG_N-1:0] MASK_RST = 4'h0;
  localparam logic [32:0] CRC_MIN_SPAN = 33'h000000003;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Events from the flash core, all on aclk
  typedef struct packed {
    logic crc_req;
    logic [31:0] crc_start_address;
    logic [31:0] crc_end_address;
    logic eval_cmd;
    logic eval_erased_ok;
    logic erase_susp_set;
    logic erase_susp_clr;
    logic prog_susp_set;
    logic prog_susp_clr;
  } fs2_core_evt_t;

  // Answer to the CRC engine
  typedef struct packed {
    logic go;
    logic abort;
  } fs2_crc_ans_t;

endpackage

/* src/fs2_crc_check.sv */
// Range check of a CRC request: decides between running and aborting.
// Assumes request and addresses from logic on the same clock.
module fs2_crc_check (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire logic req,
  input wire logic [31:0] start_addr,
  input wire logic [31:0] end_addr,
  // Decision, one cycle after the request
  output fs2_pkg::fs2_crc_ans_t ans_q
);

  // ==========================================================
  // Compare at 33 bits so start near the top does not wrap
  fs2_pkg::fs2_crc_ans_t ans_d;
  logic short_range;

  always_comb begin
    short_range = {1'b0, end_addr} < ({1'b0, start_addr} + fs2_pkg::CRC_MIN_SPAN);
    ans_d.go = req && !short_range;
    ans_d.abort = req && short_range;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ans_q <= '0;
    end else begin
      ans_q <= ans_d;
    end
  end

endmodule

/* src/fs2_sticky_bit.sv */
// One sticky interrupt bit: set by an event, cleared by a read.
// Assumes set and clear are one-cycle pulses on the same clock.
module fs2_sticky_bit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic set,
  input wire logic clr,
  // State
  output logic q
);

  logic d;

  // Set wins so an event landing on the clearing read is kept
  always_comb begin
    d = set | (q & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else begin
      q <= d;
    end
  end

endmodule

/* sim/fs2_core_model.sv */
// ==========================================================
// Flash core model: sends CRC, evaluate and suspend events to the status block.
// Assumes aclk from the bench; its tasks are called by the bench.
module fs2_core_model (
  // Clock
  input wire logic aclk,
  // Events
  output fs2_pkg::fs2_core_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial evt = '0;
  // ==========================================================
  // One-cycle pulses; data lines flip after use so a stale value never passes
  task automatic crc(input logic [31:0] s, input logic [31:0] e);
    @(posedge aclk);
    evt.crc_req <= 1'h1;
    evt.crc_start_address <= s;
    evt.crc_end_address <= e;
    @(posedge aclk);
    evt.crc_req <= 1'h0;
    evt.crc_start_address <= ~s;
    evt.crc_end_address <= ~e;
  endtask
  task automatic eval(input logic ok);
    @(posedge aclk);
    evt.eval_cmd <= 1'h1;
    evt.eval_erased_ok <= ok;
    @(posedge aclk);
    evt.eval_cmd <= 1'h0;
    evt.eval_erased_ok <= ~ok;
  endtask
  // Order: erase set, erase clear, program set, program clear
  task automatic susp(input logic [3:0] v);
    @(posedge aclk);
    {evt.erase_susp_set, evt.erase_susp_clr, evt.prog_susp_set, evt.prog_susp_clr} <= v;
    @(posedge aclk);
    {evt.erase_susp_set, evt.erase_susp_clr, evt.prog_susp_set, evt.prog_susp_clr} <= 4'h0;
  endtask
endmodule

/* sim/flash_status_two_flags_tb.sv */
// ==========================================================
// Bench for the second volatile status register over AXI4-Lite.
// Assumes the core model beside it; one access of each kind at a time.
module flash_status_two_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  fs2_pkg::fs2_core_evt_t core_evt;
  fs2_pkg::fs2_crc_ans_t crc_ans;
  int errors = 0;
  int n_tests = 0;

  always #20 aclk = ~aclk;

  fs2_core_model u_core (.aclk, .evt(core_evt));
  fs2_status_regs DUT (.aclk, .aresetn, .core_evt, .crc_ans, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq);

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // AXI4-Lite master; only the watchdog ends a wait on a dead slave
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                      input logic [3:0] sb);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awprot <= a[2:0];
    s_axi_wdata <= d;
    s_axi_wstrb <= sb;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= a[2:0];
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic st(input logic [31:0] exp);
    rchk(fs2_pkg::STATUS_OFS, exp, fs2_pkg::RESP_OKAY);
  endtask
  // CRC request, then its answer one cycle later and the resulting status word
  task automatic crc_chk(input logic [31:0] s, input logic [31:0] e, input logic [1:0] ans,
                         input logic [31:0] exp);
    u_core.crc(s, e);
    #1;
    chk({30'h0, crc_ans}, {30'h0, ans});
    st(exp);
  endtask
  task automatic irq_chk(input logic exp);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // ==========================================================
  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge aclk);
    errors++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    st(32'h0);
    rchk(fs2_pkg::IRQ_STAT_OFS, 32'h0, fs2_pkg::RESP_OKAY);
    rchk(fs2_pkg::IRQ_MASK_OFS, 32'h0, fs2_pkg::RESP_OKAY);
    wchk(fs2_pkg::STATUS_OFS, 32'hFFFFFFFF, fs2_pkg::RESP_OKAY, 4'hF);
    st(32'h0);
    crc_chk(32'h10, 32'h12, 2'h1, 32'h8);
    crc_chk(32'h10, 32'h13, 2'h2, 32'h0);
    crc_chk(32'hFFFFFFFE, 32'hFFFFFFFF, 2'h1, 32'h8);
    wchk(fs2_pkg::STATUS_OFS, 32'h0, fs2_pkg::RESP_OKAY, 4'hF);
    st(32'h8);
    u_core.eval(1'h1);
    st(32'hC);
    u_core.eval(1'h0);
    st(32'h8);
    u_core.susp(4'h8);
    st(32'hA);
    u_core.susp(4'h2);
    st(32'hB);
    u_core.susp(4'h4);
    st(32'h9);
    u_core.susp(4'h1);
    st(32'h8);
    // Interrupt: status collects CRC abort, evaluation and both suspend entries, mask gates the line
    irq_chk(1'h0);
    rchk(fs2_pkg::IRQ_STAT_OFS, 32'hF, fs2_pkg::RESP_OKAY);
    wchk(fs2_pkg::IRQ_MASK_OFS, 32'hFFFFFFFF, fs2_pkg::RESP_OKAY, 4'hF);
    rchk(fs2_pkg::IRQ_MASK_OFS, 32'hF, fs2_pkg::RESP_OKAY);
    wchk(fs2_pkg::IRQ_MASK_OFS, 32'h8, fs2_pkg::RESP_OKAY, 4'hF);
    // Lane 0 not strobed: the mask must keep its value
    wchk(fs2_pkg::IRQ_MASK_OFS, 32'h0, fs2_pkg::RESP_OKAY, 4'hE);
    rchk(fs2_pkg::IRQ_MASK_OFS, 32'h8, fs2_pkg::RESP_OKAY);
    u_core.eval(1'h1);
    irq_chk(1'h0);
    u_core.crc(32'h0, 32'h1);
    @(posedge aclk);
    irq_chk(1'h1);
    rchk(fs2_pkg::IRQ_STAT_OFS, 32'hC, fs2_pkg::RESP_OKAY);
    irq_chk(1'h0);
    rchk(fs2_pkg::IRQ_STAT_OFS, 32'h0, fs2_pkg::RESP_OKAY);
    // Unmapped place answers with an error and zero data
    rchk(8'h0C, 32'h0, fs2_pkg::RESP_SLVERR);
    wchk(8'h0C, 32'hFFFFFFFF, fs2_pkg::RESP_SLVERR, 4'hF);
    // Reset in mid-run clears every flag and the mask
    u_core.susp(4'h8);
    st(32'hE);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    st(32'h0);
    rchk(fs2_pkg::IRQ_MASK_OFS, 32'h0, fs2_pkg::RESP_OKAY);
    test_done();
  end
endmodule
